// File: design/cer_pkg.sv
// Behaviour
// - Invalid command data reports code 0x02.
// - Bad, unexecutable or misaddressed command reports 0x08.
// - Amplifier not ready reports status code 0x04.
// - Command during setting mode rejected with 0x04.
// - Second tuning point without first gives 0x04.
// - Error code stored in error information word.
// - Reduced mode: error flag at word 3 bit A.
// - Monitor mode: error flag at word 13 bit A.
// - After exchange, completed bit and response word.
// - Request dropped after completion clears completed bit.
package cer_pkg;

  // ==========================================================================
  // Error codes, one bit each except CER_CODE_NONE, which is zero.
  localparam logic [15:0] CER_CODE_NONE    = 16'h0000;
  localparam logic [15:0] CER_CODE_COMM    = 16'h0001;
  localparam logic [15:0] CER_CODE_SETVAL  = 16'h0002;
  localparam logic [15:0] CER_CODE_STATUS  = 16'h0004;
  localparam logic [15:0] CER_CODE_COMMAND = 16'h0008;
  localparam logic [15:0] CER_CODE_TRIGGER = 16'h0010;

  // ==========================================================================
  // Reset values.
  localparam logic [15:0] CER_RESP_RST = 16'h0000;
  localparam logic [15:0] CER_INFO_RST = 16'h0000;

  // ==========================================================================
  // Command sequencing states.
  typedef enum logic [1:0] {
    CER_IDLE = 2'b00,
    CER_EXEC = 2'b01,
    CER_DONE = 2'b10
  } cer_state_t;

  // ==========================================================================
  // Outcome of the sensor exchange and of command decoding.
  typedef struct packed {
    logic link_cksum_err;
    logic link_timeout;
    logic value_range_err;
    logic tuning_failed;
    logic hyst_range_err;
    logic timer_range_err;
    logic unsupported;
    logic not_executable;
    logic no_channel;
    logic multi_unit_read;
    logic amp_not_ready;
    logic amp_setting_mode;
    logic tune_first_point;
    logic tune_second_point;
  } cer_check_t;

endpackage : cer_pkg

// File: design/cer_command_error_reporter.sv
module cer_command_error_reporter
  import cer_pkg::*;
(
  // Clock and reset.
  input  wire logic        CLK_SYS,
  input  wire logic        RSTN,
  // Master command handshake.
  input  wire logic        COMMAND_TRIGGER,
  input  wire logic        MONITOR_MODE,
  output logic             CMD_COMPLETED,
  output logic [15:0]      CMD_RESPONSE,
  // Sensor exchange.
  output logic             LINK_START,
  input  wire logic        LINK_DONE,
  input  wire cer_check_t  LINK_CHECK,
  // Error reporting.
  output logic [15:0]      ERROR_INFO_WORD,
  output logic             ERR_FLAG_REDUCED,
  output logic             ERR_FLAG_MONITOR
);

  // ==========================================================================
  // Classification.
  // Only one code is reported per command, so the causes are ranked: a broken
  // link makes every later verdict meaningless, and a bad command is found
  // before the amplifier state or the data are looked at.
  function automatic logic [15:0] classify(input cer_check_t c,
                                           input logic p1_seen);
    logic [15:0] code;
    code = CER_CODE_NONE;
    if (c.link_cksum_err || c.link_timeout) begin
      code = CER_CODE_COMM;
    end else if (c.unsupported || c.not_executable || c.no_channel ||
                 c.multi_unit_read) begin
      code = CER_CODE_COMMAND;
    end else if (c.amp_not_ready || c.amp_setting_mode ||
                 (c.tune_second_point && !p1_seen)) begin
      code = CER_CODE_STATUS;
    end else if (c.value_range_err || c.tuning_failed ||
                 c.hyst_range_err || c.timer_range_err) begin
      code = CER_CODE_SETVAL;
    end
    return code;
  endfunction : classify

  // ==========================================================================
  // State.
  cer_state_t  state_r,   state_nxt;
  logic        done_r,    done_nxt;
  logic [15:0] resp_r,    resp_nxt;
  logic [15:0] info_r,    info_nxt;
  logic        flag_r,    flag_nxt;
  logic        red_r,     red_nxt;
  logic        mon_r,     mon_nxt;
  logic        p1_seen_r, p1_seen_nxt;
  logic        start_r,   start_nxt;
  logic [15:0] code;

  assign code = classify(LINK_CHECK, p1_seen_r);

  always_comb begin
    state_nxt   = state_r;
    done_nxt    = done_r;
    resp_nxt    = resp_r;
    info_nxt    = info_r;
    flag_nxt    = flag_r;
    p1_seen_nxt = p1_seen_r;
    start_nxt   = 1'b0;
    unique case (state_r)
      CER_IDLE: begin
        if (COMMAND_TRIGGER) begin
          state_nxt = CER_EXEC;
          start_nxt = 1'b1;
          flag_nxt  = 1'b0;
        end
      end
      CER_EXEC: begin
        if (!COMMAND_TRIGGER) begin
          state_nxt = CER_DONE;
          done_nxt  = 1'b1;
          resp_nxt  = CER_CODE_TRIGGER;
          info_nxt  = CER_CODE_TRIGGER;
          flag_nxt  = 1'b1;
          // An aborted command is an error too, so a first point is lost.
          p1_seen_nxt = 1'b0;
        end else if (LINK_DONE) begin
          state_nxt = CER_DONE;
          done_nxt  = 1'b1;
          resp_nxt  = code;
          if (code != CER_CODE_NONE) begin
            info_nxt    = code;
            flag_nxt    = 1'b1;
            p1_seen_nxt = 1'b0;
          end else if (LINK_CHECK.tune_first_point) begin
            p1_seen_nxt = 1'b1;
          end else if (LINK_CHECK.tune_second_point) begin
            p1_seen_nxt = 1'b0;
          end
        end
      end
      CER_DONE: begin
        if (!COMMAND_TRIGGER) begin
          state_nxt = CER_IDLE;
          done_nxt  = 1'b0;
        end
      end
      default: begin
        state_nxt = CER_IDLE;
        done_nxt  = 1'b0;
      end
    endcase
    // The flag appears in one word only, chosen by the I/O mode.
    red_nxt = flag_nxt && !MONITOR_MODE;
    mon_nxt = flag_nxt && MONITOR_MODE;
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      state_r   <= CER_IDLE;
      done_r    <= 1'b0;
      resp_r    <= CER_RESP_RST;
      info_r    <= CER_INFO_RST;
      flag_r    <= 1'b0;
      red_r     <= 1'b0;
      mon_r     <= 1'b0;
      p1_seen_r <= 1'b0;
      start_r   <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      done_r    <= done_nxt;
      resp_r    <= resp_nxt;
      info_r    <= info_nxt;
      flag_r    <= flag_nxt;
      red_r     <= red_nxt;
      mon_r     <= mon_nxt;
      p1_seen_r <= p1_seen_nxt;
      start_r   <= start_nxt;
    end
  end

  assign CMD_COMPLETED    = done_r;
  assign CMD_RESPONSE     = resp_r;
  assign ERROR_INFO_WORD  = info_r;
  assign ERR_FLAG_REDUCED = red_r;
  assign ERR_FLAG_MONITOR = mon_r;
  assign LINK_START       = start_r;

  // ==========================================================================
  // Checks.
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);

  logic ev_done, bad_comm, bad_cmd, bad_stat;
  assign ev_done  = state_r == CER_EXEC && COMMAND_TRIGGER && LINK_DONE;
  assign bad_comm = LINK_CHECK.link_cksum_err || LINK_CHECK.link_timeout;
  assign bad_cmd  = LINK_CHECK.unsupported || LINK_CHECK.not_executable ||
                    LINK_CHECK.no_channel || LINK_CHECK.multi_unit_read;
  assign bad_stat = LINK_CHECK.amp_not_ready ||
                    LINK_CHECK.amp_setting_mode ||
                    (LINK_CHECK.tune_second_point && !p1_seen_r);

  sequence s_finish(logic [15:0] c);
    ##1 (CMD_COMPLETED && CMD_RESPONSE == c);
  endsequence

  sequence s_pulse;
    LINK_START ##1 !LINK_START;
  endsequence

  chk_set_value: assert property (ev_done && !bad_comm && !bad_cmd &&
      !bad_stat && LINK_CHECK.timer_range_err |-> s_finish(CER_CODE_SETVAL))
    else $error("set value error not reported");
  chk_command_code: assert property (ev_done && !bad_comm && bad_cmd
      |-> s_finish(CER_CODE_COMMAND))
    else $error("command error not reported");
  chk_not_ready: assert property (ev_done && !bad_comm && !bad_cmd &&
      LINK_CHECK.amp_not_ready |-> s_finish(CER_CODE_STATUS))
    else $error("status error not reported");
  chk_setting_mode: assert property (ev_done &&
      !bad_comm && !bad_cmd && LINK_CHECK.amp_setting_mode
      |-> s_finish(CER_CODE_STATUS))
    else $error("setting mode command not rejected");
  chk_second_point: assert property (ev_done &&
      !bad_comm && !bad_cmd &&
      LINK_CHECK.tune_second_point && !p1_seen_r
      |-> s_finish(CER_CODE_STATUS))
    else $error("lone second point not rejected");
  chk_info_word: assert property ($rose(CMD_COMPLETED) &&
      CMD_RESPONSE != CER_CODE_NONE |-> ERROR_INFO_WORD == CMD_RESPONSE)
    else $error("error code not stored");
  chk_flag_reduced: assert property ($rose(CMD_COMPLETED) &&
      CMD_RESPONSE != CER_CODE_NONE && !$past(MONITOR_MODE)
      |-> ERR_FLAG_REDUCED && !ERR_FLAG_MONITOR)
    else $error("reduced mode flag wrong");
  chk_flag_monitor: assert property ($rose(CMD_COMPLETED) &&
      CMD_RESPONSE != CER_CODE_NONE && $past(MONITOR_MODE)
      |-> ERR_FLAG_MONITOR && !ERR_FLAG_REDUCED)
    else $error("monitor mode flag wrong");
  chk_comm_code: assert property (ev_done && bad_comm
      |-> s_finish(CER_CODE_COMM))
    else $error("communications error not reported");
  chk_trigger_drop: assert property (state_r == CER_EXEC &&
      !COMMAND_TRIGGER |-> s_finish(CER_CODE_TRIGGER))
    else $error("trigger error not reported");
  chk_done_hold: assert property (CMD_COMPLETED && COMMAND_TRIGGER
      |=> CMD_COMPLETED)
    else $error("completed bit dropped early");
  chk_done_clear: assert property (CMD_COMPLETED && !COMMAND_TRIGGER
      |=> !CMD_COMPLETED ##1 !CMD_COMPLETED)
    else $error("completed bit not cleared");
  chk_start_pulse: assert property (state_r == CER_IDLE &&
      COMMAND_TRIGGER |=> s_pulse)
    else $error("exchange start not a single pulse");
  chk_no_early_done: assert property (state_r == CER_EXEC &&
      COMMAND_TRIGGER && !LINK_DONE |=> !CMD_COMPLETED)
    else $error("completed before exchange ended");
  chk_info_keep: assert property ($rose(CMD_COMPLETED) &&
      CMD_RESPONSE == CER_CODE_NONE |-> $stable(ERROR_INFO_WORD))
    else $error("error word changed on success");
  chk_flag_take: assert property (state_r == CER_IDLE &&
      COMMAND_TRIGGER |=> !ERR_FLAG_REDUCED && !ERR_FLAG_MONITOR)
    else $error("error flag not cleared on new command");
  chk_abort_forget: assert property (state_r == CER_EXEC &&
      !COMMAND_TRIGGER |=> !p1_seen_r)
    else $error("first point kept after abort");

endmodule : cer_command_error_reporter

// File: bench/cer_link_model.sv
module cer_link_model
  import cer_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rstn,
  // Sensor exchange.
  input  wire logic       link_start,
  output logic            link_done,
  output cer_check_t      link_check,
  // Scenario control.
  input  wire logic [3:0] delay,
  input  wire cer_check_t verdict
);
  logic [4:0] cnt;
  // =====================
  // Responder.
  // Away from the done pulse the verdict lines toggle, so early sampling
  // of them shows up as a wrong code.
  always_ff @(posedge clk) begin
    link_done <= 1'b0;
    link_check <= ~link_check;
    if (!rstn) begin
      cnt <= 5'h00;
      link_check <= '0;
    end else if (link_start) begin
      cnt <= {1'b0, delay} + 5'h01;
    end else if (cnt == 5'h01) begin
      link_done <= 1'b1;
      link_check <= verdict;
      cnt <= 5'h00;
    end else if (cnt != 5'h00) begin
      cnt <= cnt - 5'h01;
    end
  end
endmodule : cer_link_model

// File: bench/tb_command_error_reporter.sv
module tb_command_error_reporter
  import cer_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        CLK_SYS, RSTN, COMMAND_TRIGGER, MONITOR_MODE;
  logic        CMD_COMPLETED, LINK_START, LINK_DONE;
  logic        ERR_FLAG_REDUCED, ERR_FLAG_MONITOR;
  logic [15:0] CMD_RESPONSE, ERROR_INFO_WORD, info_exp;
  cer_check_t  LINK_CHECK, verdict, rc;
  logic [3:0]  delay;
  logic        p1;
  int          errors, total_checks;

  cer_command_error_reporter uut (.CLK_SYS(CLK_SYS), .RSTN(RSTN),
    .COMMAND_TRIGGER(COMMAND_TRIGGER), .MONITOR_MODE(MONITOR_MODE),
    .CMD_COMPLETED(CMD_COMPLETED), .CMD_RESPONSE(CMD_RESPONSE),
    .LINK_START(LINK_START), .LINK_DONE(LINK_DONE),
    .LINK_CHECK(LINK_CHECK), .ERROR_INFO_WORD(ERROR_INFO_WORD),
    .ERR_FLAG_REDUCED(ERR_FLAG_REDUCED),
    .ERR_FLAG_MONITOR(ERR_FLAG_MONITOR));
  cer_link_model link (.clk(CLK_SYS), .rstn(RSTN), .link_start(LINK_START),
    .link_done(LINK_DONE), .link_check(LINK_CHECK), .delay(delay),
    .verdict(verdict));

  function automatic logic [15:0] exp_code(cer_check_t c, logic p1s);
    if (c.link_cksum_err || c.link_timeout) return CER_CODE_COMM;
    if (c.unsupported || c.not_executable || c.no_channel ||
        c.multi_unit_read) return CER_CODE_COMMAND;
    if (c.amp_not_ready || c.amp_setting_mode ||
        (c.tune_second_point && !p1s)) return CER_CODE_STATUS;
    if (c.value_range_err || c.tuning_failed || c.hyst_range_err ||
        c.timer_range_err) return CER_CODE_SETVAL;
    return CER_CODE_NONE;
  endfunction : exp_code

  task automatic check(logic ok, string msg);
    total_checks++;
    if (!ok) begin
      errors++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test

  // =====================
  // One command; an abort drops the trigger while the exchange runs.
  task automatic run_cmd(cer_check_t c, logic mon, logic abort, string nm);
    logic [15:0] code;
    int n;
    code = abort ? CER_CODE_TRIGGER : exp_code(c, p1);
    @(posedge CLK_SYS);
    verdict <= c;
    delay <= abort ? 4'hf : 4'($urandom_range(0, 6));
    MONITOR_MODE <= mon;
    COMMAND_TRIGGER <= 1'b1;
    if (abort) begin
      repeat (2) @(posedge CLK_SYS);
      COMMAND_TRIGGER <= 1'b0;
    end
    n = 0;
    while (CMD_COMPLETED !== 1'b1 && n < 40) begin
      @(negedge CLK_SYS);
      n++;
    end
    check(n < 40, "no completion");
    check(CMD_RESPONSE === code, "response code");
    if (code !== CER_CODE_NONE) info_exp = code;
    check(ERROR_INFO_WORD === info_exp, "error word");
    check(ERR_FLAG_REDUCED === (code != 0 && !mon), "reduced flag");
    check(ERR_FLAG_MONITOR === (code != 0 && mon), "monitor flag");
    p1 = (code === CER_CODE_NONE) && c.tune_first_point;
    if (!abort) begin
      @(posedge CLK_SYS);
      COMMAND_TRIGGER <= 1'b0;
    end
    n = 0;
    while (CMD_COMPLETED !== 1'b0 && n < 10) begin
      @(negedge CLK_SYS);
      n++;
    end
    check(n < 10, "completed stuck");
    // A stale exchange must finish before the next command is taken.
    if (abort) repeat (20) @(posedge CLK_SYS);
    $display("test %s done", nm);
  endtask : run_cmd

  initial begin
    CLK_SYS = 1'b0;
    forever #25 CLK_SYS = ~CLK_SYS;
  end

  initial begin
    #1000000;
    errors++;
    stop_test();
  end

  initial begin
    RSTN = 1'b0;
    COMMAND_TRIGGER = 1'b0;
    MONITOR_MODE = 1'b0;
    delay = 4'h0;
    verdict = '0;
    errors = 0;
    total_checks = 0;
    p1 = 1'b0;
    info_exp = CER_INFO_RST;
    void'($urandom(50));
    repeat (10) @(posedge CLK_SYS);
    check(CMD_COMPLETED === 1'b0 &&
          ERROR_INFO_WORD === CER_INFO_RST, "rst");
    RSTN <= 1'b1;
    for (int i = 0; i < 14; i++)
      run_cmd(cer_check_t'(14'h0001 << i), i[0], 1'b0,
              "single");
    run_cmd(cer_check_t'(14'h0002), 1'b0, 1'b0, "tune_first");
    run_cmd(cer_check_t'(14'h0001), 1'b1, 1'b0, "tune_second");
    run_cmd(cer_check_t'(14'h0001), 1'b0, 1'b0, "second_alone");
    run_cmd(cer_check_t'(14'h0002), 1'b1, 1'b0, "arm_first");
    run_cmd(cer_check_t'(14'h0000), 1'b1, 1'b1, "abort");
    run_cmd(cer_check_t'(14'h0002), 1'b0, 1'b1, "abort_first");
    run_cmd(cer_check_t'(14'h0001), 1'b0, 1'b0, "after_abort");
    repeat (40) begin
      rc = cer_check_t'($urandom & $urandom & 14'h3ffc);
      run_cmd(rc, 1'($urandom_range(0, 1)), 1'b0,
              "random");
    end
    stop_test();
  end
endmodule : tb_command_error_reporter
